// ==== verilog/bidir_port_with_peripheral_mux.sv ====
// Function
// - Eight pins, one bit each per register
// - Direction one makes pin input, tri-stated
// - Direction zero drives latch onto pin
// - Latch readable; read-modify-write uses latch
// - Power-on reset leaves all pins inputs
// - Pin select routes unit 2 to pin 1
// - Peripherals may override stored direction
// - Direction read returns stored bits
// - Timer oscillator disables pins 0 and 1
// - Unit 2 output wins, else capture input
// - Enhanced unit output on pin 2 unless channel A on
// - Channel A priority, tri-state on shutdown
// - SPI master clock out, else clock in
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
module bidir_port_with_peripheral_mux
   import gpio_port_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire logic [ADDR_WIDTH-1:0] regAddr,
   input  wire logic [7:0]            regWrData,
   input  wire logic                  regWrite,
   input  wire logic                  regRead,
   output logic      [7:0]            regRdData,
   input  wire periph_ctrl_t          periphCtrl,
   output periph_in_t                 periphIn,
   input  wire logic [WIDTH-1:0]      pinIn,
   output logic      [WIDTH-1:0]      pinOut,
   output logic      [WIDTH-1:0]      pinOutEnN
);

   if (WIDTH != 8) begin : g_width_check
      $error("Port width must be 8");
   end

   logic             rstSync1Q;
   logic             rstSyncQ;
   logic [WIDTH-1:0] latchQ;
   logic [WIDTH-1:0] dirQ;
   logic [WIDTH-1:0] pinSyncQ;
   logic [WIDTH-1:0] outD;
   logic [WIDTH-1:0] enND;
   logic             unit2Here;
   logic [WIDTH-1:0] oscMaskD;
   logic [7:0]       statusD;
   rd_state_t        rdStateQ;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rstSync1Q <= 1'b0;
         rstSyncQ  <= 1'b0;
      end else begin
         rstSync1Q <= 1'b1;
         rstSyncQ  <= rstSync1Q;
      end
   end

   function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                input logic [ADDR_WIDTH-1:0] b,
                                input logic                  s);
      return s && (a == b);
   endfunction

   // Latch written through either the latch or the pin register
   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         latchQ <= LATCH_RESET;
      end else if (hit(regAddr, ADDR_LATCH, regWrite) ||
                   hit(regAddr, ADDR_PIN, regWrite)) begin
         latchQ <= regWrData;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         dirQ <= DIR_RESET;
      end else if (hit(regAddr, ADDR_DIR, regWrite)) begin
         dirQ <= regWrData;
      end
   end

   // Pins treated as synchronous; one stage for a clean read value
   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         pinSyncQ <= '0;
      end else begin
         pinSyncQ <= pinIn;
      end
   end

   assign unit2Here = periphCtrl.unit2PinSelect;

   // Oscillator pins read back as zero while the analog cell owns them
   always_comb begin
      oscMaskD              = '0;
      oscMaskD[PIN_OSC_OUT] = periphCtrl.oscEnable;
      oscMaskD[PIN_OSC_IN]  = periphCtrl.oscEnable;
   end

   // Status is a live view of peripheral levels; writes to it are dropped
   always_comb begin
      statusD                = 8'h00;
      statusD[ST_OSC]        = periphCtrl.oscEnable;
      statusD[ST_UNIT2_SEL]  = periphCtrl.unit2PinSelect;
      statusD[ST_SHUTDOWN]   = periphCtrl.pwmShutdown;
      statusD[ST_SPI_MASTER] = periphCtrl.spiMaster;
   end

   always_comb begin
      outD = latchQ;
      enND = dirQ;
      if (periphCtrl.unit2Enable && unit2Here && !dirQ[PIN_UNIT2]) begin
         outD[PIN_UNIT2] = periphCtrl.unit2Out;
      end
      if (periphCtrl.eccpEnable && !dirQ[PIN_ECCP]) begin
         outD[PIN_ECCP] = periphCtrl.eccpOut;
      end
      if (periphCtrl.pwmChanAEnable && !dirQ[PIN_ECCP]) begin
         outD[PIN_ECCP] = periphCtrl.pwmChanAOut;
         if (periphCtrl.pwmShutdown && periphCtrl.pwmShutdownTristate) begin
            enND[PIN_ECCP] = 1'b1;
         end
      end
      if (periphCtrl.spiEnable && periphCtrl.spiMaster && !dirQ[PIN_SCK]) begin
         outD[PIN_SCK] = periphCtrl.spiClkOut;
      end
      // Oscillator is analog; digital driver must stay off
      if (periphCtrl.oscEnable) begin
         enND[PIN_OSC_OUT] = 1'b1;
         enND[PIN_OSC_IN]  = 1'b1;
         outD[PIN_OSC_OUT] = 1'b0;
         outD[PIN_OSC_IN]  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         pinOut    <= '0;
         pinOutEnN <= '1;
      end else begin
         pinOut    <= outD;
         pinOutEnN <= enND;
      end
   end

   // Capture and SPI clock inputs only seen when the pin is an input; timer count input ignores direction
   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         periphIn <= '0;
      end else begin
         periphIn.timerCountIn  <= periphCtrl.oscEnable ? 1'b0 : pinSyncQ[PIN_OSC_OUT];
         periphIn.unit2CaptureIn <= unit2Here && dirQ[PIN_UNIT2] && !periphCtrl.oscEnable
                                    && pinSyncQ[PIN_UNIT2];
         periphIn.eccpCaptureIn <= dirQ[PIN_ECCP] && pinSyncQ[PIN_ECCP];
         periphIn.spiClkIn      <= dirQ[PIN_SCK] && pinSyncQ[PIN_SCK];
      end
   end

   always_ff @(posedge clk_sys or negedge rstSyncQ) begin
      if (!rstSyncQ) begin
         rdStateQ  <= RD_IDLE;
         regRdData <= '0;
      end else begin
         case (regRead)
            1'b1: begin
               rdStateQ <= RD_VALID;
               case (regAddr)
                  ADDR_PIN: begin
                     regRdData <= pinSyncQ & ~oscMaskD;
                  end
                  ADDR_LATCH: begin
                     regRdData <= latchQ;
                  end
                  ADDR_DIR: begin
                     regRdData <= dirQ;
                  end
                  ADDR_STATUS: begin
                     regRdData <= statusD;
                  end
                  default: begin
                     regRdData <= '0;
                  end
               endcase
            end
            default: begin
               rdStateQ  <= RD_IDLE;
               regRdData <= '0;
            end
         endcase
      end
   end

   property p_dir_write;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      hit(regAddr, ADDR_DIR, regWrite) |=> dirQ == $past(regWrData);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction not stored");

   property p_input_tristate;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (dirQ[5] && dirQ[4]) |=> (pinOutEnN[5] && pinOutEnN[4]);
   endproperty
   a_input_tristate: assert property (p_input_tristate) else $error("input pin driven");

   property p_output_latch;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (!dirQ[7] && !periphCtrl.oscEnable) |=> (!pinOutEnN[7] && pinOut[7] == $past(latchQ[7]));
   endproperty
   a_output_latch: assert property (p_output_latch) else $error("latch not driven");

   sequence s_latch_write;
      hit(regAddr, ADDR_LATCH, regWrite) ##1 hit(regAddr, ADDR_LATCH, regRead);
   endsequence
   property p_latch_rmw;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      s_latch_write |=> regRdData == $past(regWrData, 2);
   endproperty
   a_latch_rmw: assert property (p_latch_rmw) else $error("latch readback wrong");

   property p_reset_inputs;
      @(posedge clk_sys) $rose(rstSyncQ) |-> (pinOutEnN == '1 && dirQ == DIR_RESET);
   endproperty
   a_reset_inputs: assert property (p_reset_inputs) else $error("not input after reset");

   property p_dir_read;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      hit(regAddr, ADDR_DIR, regRead) |=> regRdData == $past(dirQ);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

   property p_osc_off;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      periphCtrl.oscEnable |=> (pinOutEnN[1:0] == 2'b11);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator pins driven");

   property p_unit2_out;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (periphCtrl.unit2Enable && unit2Here && !dirQ[1] && !periphCtrl.oscEnable)
      |=> pinOut[1] == $past(periphCtrl.unit2Out);
   endproperty
   a_unit2_out: assert property (p_unit2_out) else $error("unit 2 output lost");

   property p_shutdown_tri;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (periphCtrl.pwmChanAEnable && periphCtrl.pwmShutdown && periphCtrl.pwmShutdownTristate)
      |=> pinOutEnN[2];
   endproperty
   a_shutdown_tri: assert property (p_shutdown_tri) else $error("shutdown not tri-state");

   property p_sck_out;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (periphCtrl.spiEnable && periphCtrl.spiMaster && !dirQ[3])
      |=> pinOut[3] == $past(periphCtrl.spiClkOut);
   endproperty
   a_sck_out: assert property (p_sck_out) else $error("SPI clock not driven");

   property p_latch_write;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      hit(regAddr, ADDR_LATCH, regWrite) |=> latchQ == $past(regWrData);
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch not written");

   property p_pin_write;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      hit(regAddr, ADDR_PIN, regWrite) |=> latchQ == $past(regWrData);
   endproperty
   a_pin_write: assert property (p_pin_write) else $error("pin write missed latch");

   property p_pin_read;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (hit(regAddr, ADDR_PIN, regRead) && !periphCtrl.oscEnable)
      |=> regRdData == $past(pinSyncQ);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

   property p_osc_read;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (hit(regAddr, ADDR_PIN, regRead) && periphCtrl.oscEnable)
      |=> regRdData[1:0] == 2'b00;
   endproperty
   a_osc_read: assert property (p_osc_read) else $error("oscillator pins read");

   property p_timer_quiet;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      periphCtrl.oscEnable |=> !periphIn.timerCountIn;
   endproperty
   a_timer_quiet: assert property (p_timer_quiet) else $error("count input not quiet");

   // Direction only moves on a direction write, never by an override
   property p_dir_hold;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      !hit(regAddr, ADDR_DIR, regWrite) |=> $stable(dirQ);
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("direction changed");

   property p_status_ro;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      hit(regAddr, ADDR_STATUS, regWrite) |=> ($stable(dirQ) && $stable(latchQ));
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write stored");

   property p_rd_idle;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      !regRead |=> (rdStateQ == RD_IDLE && regRdData == 8'h00);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

   property p_eccp_out;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (periphCtrl.eccpEnable && !periphCtrl.pwmChanAEnable && !dirQ[PIN_ECCP])
      |=> pinOut[PIN_ECCP] == $past(periphCtrl.eccpOut);
   endproperty
   a_eccp_out: assert property (p_eccp_out) else $error("enhanced output lost");

   property p_chan_a_out;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (periphCtrl.pwmChanAEnable && !dirQ[PIN_ECCP])
      |=> pinOut[PIN_ECCP] == $past(periphCtrl.pwmChanAOut);
   endproperty
   a_chan_a_out: assert property (p_chan_a_out) else $error("channel A lost");

   property p_unit2_capture;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (unit2Here && dirQ[PIN_UNIT2] && !periphCtrl.oscEnable)
      |=> periphIn.unit2CaptureIn == $past(pinSyncQ[PIN_UNIT2]);
   endproperty
   a_unit2_capture: assert property (p_unit2_capture) else $error("capture lost");

   property p_eccp_capture;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      dirQ[PIN_ECCP] |=> periphIn.eccpCaptureIn == $past(pinSyncQ[PIN_ECCP]);
   endproperty
   a_eccp_capture: assert property (p_eccp_capture) else $error("capture lost");

   property p_sck_in;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      dirQ[PIN_SCK] |=> periphIn.spiClkIn == $past(pinSyncQ[PIN_SCK]);
   endproperty
   a_sck_in: assert property (p_sck_in) else $error("SPI clock input lost");

   property p_unit2_away;
      @(posedge clk_sys) disable iff (!rstSyncQ)
      (!unit2Here && !dirQ[PIN_UNIT2] && !periphCtrl.oscEnable)
      |=> pinOut[PIN_UNIT2] == $past(latchQ[PIN_UNIT2]);
   endproperty
   a_unit2_away: assert property (p_unit2_away) else $error("unit 2 not routed away");

endmodule

// ==== verilog/gpio_port_pkg.sv ====
package gpio_port_pkg;

   localparam int          PORT_WIDTH    = 8;
   localparam int          ADDR_WIDTH    = 2;

   // Register offsets
   localparam logic [1:0]  ADDR_PIN      = 2'h0;
   localparam logic [1:0]  ADDR_LATCH    = 2'h1;
   localparam logic [1:0]  ADDR_DIR      = 2'h2;
   localparam logic [1:0]  ADDR_STATUS   = 2'h3;

   // Reset values: all inputs, latch cleared
   localparam logic [7:0]  DIR_RESET     = 8'hFF;
   localparam logic [7:0]  LATCH_RESET   = 8'h00;

   // Pin positions
   localparam int          PIN_OSC_OUT   = 0;
   localparam int          PIN_OSC_IN    = 1;
   localparam int          PIN_UNIT2     = 1;
   localparam int          PIN_ECCP      = 2;
   localparam int          PIN_SCK       = 3;

   // Status register field positions
   localparam int          ST_OSC        = 0;
   localparam int          ST_UNIT2_SEL  = 1;
   localparam int          ST_SHUTDOWN   = 2;
   localparam int          ST_SPI_MASTER = 3;

   typedef struct packed {
      logic oscEnable;
      logic unit2PinSelect;
      logic unit2Enable;
      logic unit2Out;
      logic eccpEnable;
      logic eccpOut;
      logic pwmChanAEnable;
      logic pwmChanAOut;
      logic pwmShutdown;
      logic pwmShutdownTristate;
      logic spiEnable;
      logic spiMaster;
      logic spiClkOut;
   } periph_ctrl_t;

   typedef struct packed {
      logic timerCountIn;
      logic unit2CaptureIn;
      logic eccpCaptureIn;
      logic spiClkIn;
   } periph_in_t;

   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_VALID = 2'b01
   } rd_state_t;

endpackage

// ==== verif/port_pin_model.sv ====
`timescale 1ns/100ps
module port_pin_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOutEnN,
   input  wire logic [7:0] extVal,
   input  wire logic [7:0] extEn,
   output logic      [7:0] pinLevel
);
   logic [7:0] lastLevel = 8'h00;
   always @(posedge clk_sys) begin
      lastLevel <= pinLevel;
   end
   // Floating line toggles, so a stale level never reads as a match
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pinOutEnN[i]) begin
            pinLevel[i] = pinOut[i];
         end else if (extEn[i]) begin
            pinLevel[i] = extVal[i];
         end else begin
            pinLevel[i] = ~lastLevel[i];
         end
      end
   end
endmodule

// ==== verif/bidir_port_with_peripheral_mux_tb_top.sv ====
`timescale 1ns/100ps
module bidir_port_with_peripheral_mux_tb_top import gpio_port_pkg::*; ;
   logic                  clk_sys   = 1'b0;
   logic                  rstn      = 1'b0;
   logic [ADDR_WIDTH-1:0] regAddr   = 2'h0;
   logic [7:0]            regWrData = 8'h00;
   logic                  regWrite  = 1'b0;
   logic                  regRead   = 1'b0;
   logic [7:0]            regRdData;
   periph_ctrl_t          periphCtrl = '0;
   periph_in_t            periphIn;
   logic [7:0]            pinIn, pinOut, pinOutEnN;
   logic [7:0]            extVal = 8'h00;
   logic [7:0]            extEn  = 8'h00;
   periph_ctrl_t          pc;
   int                    fails = 0;
   int                    compares = 0;
   always #5 clk_sys = ~clk_sys;
   bidir_port_with_peripheral_mux dut_u (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .periphCtrl(periphCtrl), .periphIn(periphIn), .pinIn(pinIn), .pinOut(pinOut),
      .pinOutEnN(pinOutEnN));
   port_pin_model pins_u (.clk_sys(clk_sys), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
      .extVal(extVal), .extEn(extEn), .pinLevel(pinIn));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rdchk(input string name, input logic [1:0] a, input logic [7:0] exp,
                        input logic [7:0] mask);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk(name, regRdData & mask, exp);
   endtask
   // Write then read the same register on the next cycle, no gap
   task automatic wrrd(input logic [1:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      regRead  <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk("wrrd", regRdData, exp);
   endtask
   task automatic setp(input periph_ctrl_t p);
      @(posedge clk_sys);
      periphCtrl <= p;
   endtask
   // Pin paths lag by up to three cycles; four leaves margin
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset();
      rdchk("dir", ADDR_DIR, 8'hFF, 8'hFF);
      rdchk("latch", ADDR_LATCH, 8'h00, 8'hFF);
      chk("enN", pinOutEnN, 8'hFF);
      chk("out", pinOut, 8'h00);
   endtask
   task automatic t_drive();
      wr(ADDR_DIR, 8'h00);
      wr(ADDR_LATCH, 8'hA5);
      settle();
      chk("out", pinOut, 8'hA5);
      chk("enN", pinOutEnN, 8'h00);
      wr(ADDR_PIN, 8'h3C);
      rdchk("latch", ADDR_LATCH, 8'h3C, 8'hFF);
      settle();
      rdchk("pin", ADDR_PIN, 8'h3C, 8'hFF);
   endtask
   task automatic t_input();
      wr(ADDR_DIR, 8'hFF);
      extVal <= 8'h5A;
      extEn <= 8'hFF;
      settle();
      chk("enN", pinOutEnN, 8'hFF);
      rdchk("pin", ADDR_PIN, 8'h5A, 8'hFF);
      chk("capin", {4'h0, periphIn}, 8'h01);
      extVal <= 8'hA5;
      settle();
      chk("capin", {4'h0, periphIn}, 8'h0A);
      rdchk("latch", ADDR_LATCH, 8'h3C, 8'hFF);
      wrrd(ADDR_LATCH, 8'h3C | 8'h80, 8'hBC);
      rdchk("latch", ADDR_LATCH, 8'hBC, 8'hFF);
   endtask
   task automatic t_osc();
      wr(ADDR_DIR, 8'h00);
      wr(ADDR_LATCH, 8'hFF);
      extEn <= 8'h01;
      pc = '0;
      pc.oscEnable = 1'b1;
      setp(pc);
      settle();
      chk("enN", pinOutEnN, 8'h03);
      chk("out", pinOut, 8'hFC);
      rdchk("pin", ADDR_PIN, 8'hFC, 8'hFF);
      chk("tmr", {7'h00, periphIn.timerCountIn}, 8'h00);
      rdchk("dir", ADDR_DIR, 8'h00, 8'hFF);
   endtask
   task automatic t_unit2();
      wr(ADDR_LATCH, 8'h00);
      pc = '0;
      pc.unit2Enable = 1'b1;
      pc.unit2PinSelect = 1'b1;
      pc.unit2Out = 1'b1;
      setp(pc);
      settle();
      chk("out", pinOut, 8'h02);
      pc.unit2PinSelect = 1'b0;
      setp(pc);
      settle();
      chk("out", pinOut, 8'h00);
      pc.unit2PinSelect = 1'b1;
      setp(pc);
      wr(ADDR_DIR, 8'h02);
      extVal <= 8'h02;
      extEn <= 8'h02;
      settle();
      chk("cap2", {7'h00, periphIn.unit2CaptureIn}, 8'h01);
   endtask
   task automatic t_eccp();
      wr(ADDR_DIR, 8'h00);
      extEn <= 8'h00;
      pc = '0;
      pc.eccpEnable = 1'b1;
      pc.eccpOut = 1'b1;
      setp(pc);
      settle();
      chk("out", pinOut, 8'h04);
      pc.pwmChanAEnable = 1'b1;
      setp(pc);
      settle();
      chk("out", pinOut, 8'h00);
      pc.pwmShutdown = 1'b1;
      pc.pwmShutdownTristate = 1'b1;
      setp(pc);
      settle();
      chk("enN", pinOutEnN, 8'h04);
      rdchk("status", ADDR_STATUS, 8'h04, 8'h0F);
      wr(ADDR_STATUS, 8'h0B);
      rdchk("status", ADDR_STATUS, 8'h04, 8'h0F);
   endtask
   task automatic t_spi();
      pc = '0;
      pc.spiEnable = 1'b1;
      pc.spiMaster = 1'b1;
      pc.spiClkOut = 1'b1;
      setp(pc);
      settle();
      chk("out", pinOut, 8'h08);
      pc.spiMaster = 1'b0;
      setp(pc);
      wr(ADDR_DIR, 8'h08);
      extVal <= 8'h08;
      extEn <= 8'h08;
      settle();
      chk("sck", {7'h00, periphIn.spiClkIn}, 8'h01);
   endtask
   task automatic give_verdict();
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_drive();
      t_input();
      t_osc();
      t_unit2();
      t_eccp();
      t_spi();
      give_verdict();
   end
   // Bounded run: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      give_verdict();
   end
endmodule
